/* core/dbr_baud_gen.sv */
`timescale 1ns/1ps
module dbr_baud_gen (
  // Clock and reset
  input  wire logic                     mclk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     ce_in,
  // Divisor
  input  wire logic [dbr_pkg::DIV_W-1:0] clock_divisor_in,
  // Ticks
  output logic                          sample_tick_out,
  output logic                          baud_tick_out
);
  import dbr_pkg::*;

  logic [DIV_W-1:0]   div_cnt;
  logic [PHASE_W-1:0] phase;

  wire div_off   = (clock_divisor_in == DIV_CNT_RST);
  wire div_wrap  = (div_cnt <= {{(DIV_W-1){1'b0}}, 1'b1});
  wire phase_end = (phase == PHASE_LAST);

  // Divide by the divisor gives the sixteen-times sampling enable
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt         <= DIV_CNT_RST;
      sample_tick_out <= 1'b0;
    end else if (ce_in) begin
      if (div_off) begin
        div_cnt         <= DIV_CNT_RST;
        sample_tick_out <= 1'b0;
      end else if (div_wrap) begin
        div_cnt         <= clock_divisor_in;
        sample_tick_out <= 1'b1;
      end else begin
        div_cnt         <= div_cnt - {{(DIV_W-1){1'b0}}, 1'b1};
        sample_tick_out <= 1'b0;
      end
    end
  end

  // Further divide by sixteen for the shared bit-period clock
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase         <= PHASE_RST;
      baud_tick_out <= 1'b0;
    end else if (ce_in) begin
      if (div_off) begin
        phase         <= PHASE_RST;
        baud_tick_out <= 1'b0;
      end else if (sample_tick_out) begin
        phase         <= phase + 4'h1;
        baud_tick_out <= phase_end;
      end else begin
        baud_tick_out <= 1'b0;
      end
    end
  end

endmodule

/* core/dbr_receiver.sv */
`timescale 1ns/1ps
module dbr_receiver (
  // Clock, reset, enable
  input  wire logic                        mclk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        ce_in,
  // Configuration
  input  wire logic [dbr_pkg::DIV_W-1:0]   clock_divisor_in,
  input  wire logic [dbr_pkg::KIND_W-1:0]  check_kind_field_in,
  // Commands and holding register read strobe
  input  wire dbr_pkg::dbr_cmd_t           control_reg_in,
  input  wire logic                        hold_read_in,
  // Serial line
  input  wire logic                        serial_rx_line_in,
  // Results
  output logic [dbr_pkg::DATA_BITS-1:0]    receive_holding_reg_out,
  output dbr_pkg::dbr_status_t             status_reg_out,
  output logic                             baud_tick_out
);
  import dbr_pkg::*;

  // Shared timing source; the transmitter takes baud_tick_out
  logic sample_tick;

  dbr_baud_gen u_baud (
    .mclk_in          (mclk_in),
    .rst_n_in         (rst_n_in),
    .ce_in            (ce_in),
    .clock_divisor_in (clock_divisor_in),
    .sample_tick_out  (sample_tick),
    .baud_tick_out    (baud_tick_out)
  );

  // Expected parity bit for the chosen parity kind
  function automatic logic expect_parity(input logic [DATA_BITS-1:0] data,
                                         input logic [KIND_W-1:0]    kind);
    logic bit_val;
    bit_val = 1'b0;
    case (kind)
      KIND_EVEN:  bit_val = ^data;
      KIND_ODD:   bit_val = ~(^data);
      KIND_SPACE: bit_val = 1'b0;
      KIND_MARK:  bit_val = 1'b1;
      default:    bit_val = 1'b0;
    endcase
    return bit_val;
  endfunction

  // Line synchroniser and agreement filter
  logic rx_s1;
  logic rx_s2;
  logic rx_s3;
  logic rx_line;

  // Three stages; the level moves only when the last two agree,
  // so a single metastable settle cannot glitch the hunt counter
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_s3   <= 1'b1;
      rx_line <= 1'b1;
    end else if (ce_in) begin
      rx_s1 <= serial_rx_line_in;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) begin
        rx_line <= rx_s3;
      end
    end
  end

  // Receive state
  dbr_state_t           state;
  logic [CNT_W-1:0]     cnt;
  logic [IDX_W-1:0]     bit_idx;
  logic [DATA_BITS-1:0] shift;
  logic                 first_wait;
  logic                 par_bit;
  logic                 disable_pending;

  dbr_state_t           next_state;
  logic [CNT_W-1:0]     next_cnt;
  logic [IDX_W-1:0]     next_bit_idx;
  logic [DATA_BITS-1:0] next_shift;
  logic                 next_first_wait;
  logic                 next_par_bit;
  logic                 next_disable_pending;
  logic                 char_done;

  // Decodes
  wire cmd_en     = control_reg_in.receive_enable_cmd;
  wire cmd_dis    = control_reg_in.receive_disable_cmd;
  wire cmd_rst    = control_reg_in.receive_reset_cmd;
  wire cmd_sta    = control_reg_in.status_reset_cmd;
  wire parity_on  = ~check_kind_field_in[KIND_NONE_BIT];
  wire [CNT_W-1:0] cnt_inc = cnt + 5'h01;
  wire [CNT_W-1:0] target  = first_wait ? FIRST_SAMPLE_TICKS : BIT_TICKS;
  wire busy       = (state == ST_DATA) || (state == ST_PARITY) || (state == ST_STOP);
  wire sample_due = sample_tick && busy && (cnt_inc == target);
  wire start_ok   = sample_tick && !rx_line && (cnt_inc == START_QUAL_TICKS);
  wire last_data  = (bit_idx == LAST_DATA_IDX);
  wire par_bad    = parity_on && (par_bit != expect_parity(shift, check_kind_field_in));
  wire stop_low   = !rx_line;

  always_comb begin
    next_state           = state;
    next_cnt             = cnt;
    next_bit_idx         = bit_idx;
    next_shift           = shift;
    next_first_wait      = first_wait;
    next_par_bit         = par_bit;
    next_disable_pending = disable_pending;
    char_done            = 1'b0;
    case (state)
      ST_OFF: begin
        next_cnt             = CNT_RST;
        next_disable_pending = 1'b0;
        if (cmd_en && !cmd_dis) begin
          next_state = ST_HUNT;
        end
      end
      ST_HUNT: begin
        if (cmd_dis) begin
          next_state = ST_OFF;
          next_cnt   = CNT_RST;
        end else if (sample_tick) begin
          if (rx_line) begin
            next_cnt = CNT_RST;
          end else if (start_ok) begin
            next_cnt        = cnt_inc;
            next_state      = ST_DATA;
            next_first_wait = 1'b1;
            next_bit_idx    = IDX_RST;
          end else begin
            next_cnt = cnt_inc;
          end
        end
      end
      ST_DATA: begin
        if (sample_tick) begin
          next_cnt = cnt_inc;
        end
        if (sample_due) begin
          next_cnt        = CNT_RST;
          next_first_wait = 1'b0;
          next_shift      = {rx_line, shift[DATA_BITS-1:1]};
          if (last_data) begin
            next_state = parity_on ? ST_PARITY : ST_STOP;
          end else begin
            next_bit_idx = bit_idx + 3'h1;
          end
        end
      end
      ST_PARITY: begin
        if (sample_tick) begin
          next_cnt = cnt_inc;
        end
        if (sample_due) begin
          next_cnt     = CNT_RST;
          next_par_bit = rx_line;
          next_state   = ST_STOP;
        end
      end
      ST_STOP: begin
        if (sample_tick) begin
          next_cnt = cnt_inc;
        end
        if (sample_due) begin
          next_cnt  = CNT_RST;
          char_done = 1'b1;
          if (disable_pending || cmd_dis) begin
            next_state = ST_OFF;
          end else begin
            next_state = ST_HUNT;
          end
          next_disable_pending = 1'b0;
        end
      end
      default: begin
        next_state = ST_OFF;
        next_cnt   = CNT_RST;
      end
    endcase
    // A disable while a character is under way waits for its stop bit
    if (busy && cmd_dis && !char_done) begin
      next_disable_pending = 1'b1;
    end
    // Reset beats everything, including a character finishing now
    if (cmd_rst) begin
      next_state           = ST_OFF;
      next_cnt             = CNT_RST;
      next_bit_idx         = IDX_RST;
      next_first_wait      = 1'b0;
      next_disable_pending = 1'b0;
      char_done            = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state           <= ST_OFF;
      cnt             <= CNT_RST;
      bit_idx         <= IDX_RST;
      first_wait      <= 1'b0;
      disable_pending <= 1'b0;
    end else if (ce_in) begin
      state           <= next_state;
      cnt             <= next_cnt;
      bit_idx         <= next_bit_idx;
      first_wait      <= next_first_wait;
      disable_pending <= next_disable_pending;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift   <= DATA_RST;
      par_bit <= 1'b0;
    end else if (ce_in) begin
      shift   <= next_shift;
      par_bit <= next_par_bit;
    end
  end

  // Holding register and flags; a set always beats a clear in one cycle
  wire overrun_now = char_done && status_reg_out.receive_ready_flag && !hold_read_in;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      receive_holding_reg_out <= DATA_RST;
    end else if (ce_in && char_done) begin
      receive_holding_reg_out <= shift;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_reg_out.receive_ready_flag <= 1'b0;
    end else if (ce_in) begin
      if (char_done) begin
        status_reg_out.receive_ready_flag <= 1'b1;
      end else if (hold_read_in) begin
        status_reg_out.receive_ready_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_reg_out.overrun_flag <= 1'b0;
    end else if (ce_in) begin
      if (overrun_now) begin
        status_reg_out.overrun_flag <= 1'b1;
      end else if (cmd_sta) begin
        status_reg_out.overrun_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_reg_out.parity_error_flag <= 1'b0;
    end else if (ce_in) begin
      if (char_done && par_bad) begin
        status_reg_out.parity_error_flag <= 1'b1;
      end else if (cmd_sta) begin
        status_reg_out.parity_error_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_reg_out.framing_error_flag <= 1'b0;
    end else if (ce_in) begin
      if (char_done && stop_low) begin
        status_reg_out.framing_error_flag <= 1'b1;
      end else if (cmd_sta) begin
        status_reg_out.framing_error_flag <= 1'b0;
      end
    end
  end

  // No idle timeout exists, so the enable view is just the state
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_reg_out.receiver_on <= 1'b0;
    end else if (ce_in) begin
      status_reg_out.receiver_on <= (next_state != ST_OFF);
    end
  end

endmodule

/* inc/dbr_pkg.sv */
// Overview of operation
// - Asynchronous only, 8-bit characters, optional parity, no serial clock pin.
// - Receiver and transmitter run independently but share one baud clock source.
// - No receive idle timeout, no transmit guard delay; standard controller behaviour.
// - Baud clock is master clock divided by sixteen times the clock divisor.
// - Divisor zero stops the baud clock; the whole serial port stays inactive.
// - Divisor spans 1 to 65535, baud from master/16 down to master/(16*65535).
// - Receiver disabled after reset; enable command starts hunting for a start bit.
// - Disable stops an idle receiver at once, a busy one after its stop bit.
// - Receive reset aborts at once, disables, discards any partial character.
// - Sample at sixteen times baud; start accepted when low lasts over 7 ticks.
// - First data sample 24 sampling ticks after the detected falling edge.
// - Each later sample 16 ticks after the previous, through parity and stop.
// - Completed character goes to holding register and sets ready; reading clears it.
// - Character completing while ready is set and not read in that cycle raises overrun; status reset clears it.
// - Parity mismatch per parity kind sets parity error with ready; status reset clears.
// - Stop bit sampled low sets framing error with ready; status reset clears it.
package dbr_pkg;

  // Widths and counts
  localparam int DIV_W            = 16;
  localparam int DATA_BITS        = 8;
  localparam int OVERSAMPLE       = 16;
  localparam int PHASE_W          = 4;
  localparam int CNT_W            = 5;
  localparam int IDX_W            = 3;
  localparam int KIND_W           = 3;

  // Receive timing in sampling ticks, and the last data bit index
  localparam logic [CNT_W-1:0] START_QUAL_TICKS   = 5'h08;
  localparam logic [CNT_W-1:0] FIRST_SAMPLE_TICKS = 5'h18;
  localparam logic [CNT_W-1:0] BIT_TICKS          = 5'h10;
  localparam logic [IDX_W-1:0] LAST_DATA_IDX      = 3'h7;

  // Parity kind encodings
  localparam logic [KIND_W-1:0] KIND_EVEN  = 3'h0;
  localparam logic [KIND_W-1:0] KIND_ODD   = 3'h1;
  localparam logic [KIND_W-1:0] KIND_SPACE = 3'h2;
  localparam logic [KIND_W-1:0] KIND_MARK  = 3'h3;
  localparam int                KIND_NONE_BIT = 2;

  // Reset values and the last phase
  localparam logic [DIV_W-1:0]     DIV_CNT_RST = 16'h0000;
  localparam logic [PHASE_W-1:0]   PHASE_RST   = 4'h0;
  localparam logic [PHASE_W-1:0]   PHASE_LAST  = 4'hF;
  localparam logic [DATA_BITS-1:0] DATA_RST    = 8'h00;
  localparam logic [CNT_W-1:0]     CNT_RST     = 5'h00;
  localparam logic [IDX_W-1:0]     IDX_RST     = 3'h0;

  typedef enum {
    ST_OFF,
    ST_HUNT,
    ST_DATA,
    ST_PARITY,
    ST_STOP
  } dbr_state_t;

  // Control register command bits, each a one-cycle write pulse
  typedef struct packed {
    logic receive_enable_cmd;
    logic receive_disable_cmd;
    logic receive_reset_cmd;
    logic status_reset_cmd;
  } dbr_cmd_t;

  // Status register view of the receiver
  typedef struct packed {
    logic receive_ready_flag;
    logic overrun_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic receiver_on;
  } dbr_status_t;

endpackage

/* test/dbr_receiver_sva.sv */
`timescale 1ns/1ps
module dbr_receiver_sva (
  // Clock and reset
  input wire logic                          mclk_in,
  input wire logic                          rst_n_in,
  input wire logic                          ce_in,
  // Watched ports
  input wire logic [dbr_pkg::DIV_W-1:0]     clock_divisor_in,
  input wire dbr_pkg::dbr_cmd_t             control_reg_in,
  input wire logic [dbr_pkg::DATA_BITS-1:0] receive_holding_reg_out,
  input wire dbr_pkg::dbr_status_t          status_reg_out,
  input wire logic                          baud_tick_out
);
  import dbr_pkg::*;
  logic [4:0] gap;
  logic       seen;
  // Gap since last tick; only trusted after a tick seen at divisor one
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap  <= 5'h00;
      seen <= 1'b0;
    end else if (ce_in) begin
      gap  <= baud_tick_out ? 5'h00 : gap + 5'h01;
      seen <= (clock_divisor_in == 16'h0001) && (seen || baud_tick_out);
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  a_enable_turns_on: assert property (ce_in && control_reg_in[3:1] == 3'h4
    |=> status_reg_out.receiver_on) else $error("enable did not start receiver");
  a_on_needs_enable: assert property ($rose(status_reg_out.receiver_on)
    |-> $past(control_reg_in.receive_enable_cmd)) else $error("receiver on without enable");
  a_reset_stops_rx: assert property (ce_in && control_reg_in.receive_reset_cmd
    |=> !status_reg_out.receiver_on && !$rose(status_reg_out.receive_ready_flag))
    else $error("receive reset did not abort");
  a_hold_with_ready: assert property ($changed(receive_holding_reg_out)
    |-> status_reg_out.receive_ready_flag) else $error("holding changed without ready");
  a_overrun_cause: assert property ($rose(status_reg_out.overrun_flag)
    |-> $past(status_reg_out.receive_ready_flag)) else $error("overrun without ready");
  a_overrun_sticky: assert property ($fell(status_reg_out.overrun_flag)
    |-> $past(control_reg_in.status_reset_cmd)) else $error("overrun dropped alone");
  a_error_sticky: assert property ($fell(status_reg_out.parity_error_flag) ||
    $fell(status_reg_out.framing_error_flag) |-> $past(control_reg_in.status_reset_cmd))
    else $error("error flag dropped alone");
  a_error_with_ready: assert property ($rose(status_reg_out.parity_error_flag) ||
    $rose(status_reg_out.framing_error_flag) |-> status_reg_out.receive_ready_flag)
    else $error("error flag without ready");
  a_baud_period: assert property (seen && clock_divisor_in == 16'h0001
    |-> baud_tick_out == (gap == 5'h0F)) else $error("baud tick period wrong");
  a_div_zero_quiet: assert property (clock_divisor_in == 16'h0000 &&
    $past(clock_divisor_in) == 16'h0000 |-> !baud_tick_out) else $error("tick at divisor zero");
endmodule

bind dbr_receiver dbr_receiver_sva u_sva (
  .mclk_in                 (mclk_in),
  .rst_n_in                (rst_n_in),
  .ce_in                   (ce_in),
  .clock_divisor_in        (clock_divisor_in),
  .control_reg_in          (control_reg_in),
  .receive_holding_reg_out (receive_holding_reg_out),
  .status_reg_out          (status_reg_out),
  .baud_tick_out           (baud_tick_out)
);

/* test/dbr_term_model.sv */
`timescale 1ns/1ps
module dbr_term_model (
  // Clock
  input  wire logic mclk_in,
  // Serial line, idle high
  output logic      serial_tx_line_out
);
  initial serial_tx_line_out = 1'b1;
  task automatic hold_bit(input logic b, input int n);
    serial_tx_line_out = b;
    repeat (n) @(negedge mclk_in);
  endtask
  // Start, data LSB first, optional parity, stop
  task automatic send(input logic [7:0] d, input int par, input logic stop, input int bd);
    int i;
    hold_bit(1'b0, 16 * bd);
    for (i = 0; i < 8; i++) hold_bit(d[i], 16 * bd);
    if (par >= 0) hold_bit(par[0], 16 * bd);
    // Short low stop so its tail is not taken for a new start
    if (stop) hold_bit(1'b1, 16 * bd);
    else begin
      hold_bit(1'b0, 11 * bd);
      hold_bit(1'b1, 5 * bd);
    end
  endtask
  task automatic glitch(input int n);
    hold_bit(1'b0, n);
    hold_bit(1'b1, 32);
  endtask
endmodule

/* test/debug_uart_baud_receiver_bench.sv */
`timescale 1ns/1ps
module debug_uart_baud_receiver_bench;
  import dbr_pkg::*;
  localparam dbr_cmd_t C_NO = 4'h0;
  localparam dbr_cmd_t C_EN = 4'h8;
  localparam dbr_cmd_t C_DI = 4'h4;
  localparam dbr_cmd_t C_RS = 4'h2;
  localparam dbr_cmd_t C_ST = 4'h1;
  logic             mclk = 1'b0;
  logic             rst_n = 1'b0;
  logic             ce = 1'b1;
  logic [DIV_W-1:0] div = 16'h0001;
  logic [2:0]       kind = 3'h4;
  dbr_cmd_t         cmd = C_NO;
  logic             rd = 1'b0;
  wire logic        line;
  logic [7:0]       hold;
  dbr_status_t      stat;
  logic             tick;
  int               bad_count = 0;
  int               n_tests = 0;
  int               seed = 88;
  int               i, m_rdy, m_ovr, m_pe, m_fe, m_on, m_pend;
  logic [7:0]       m_q[$];
  always #2 mclk = ~mclk;
  dbr_term_model term (.mclk_in(mclk), .serial_tx_line_out(line));
  dbr_receiver DUT (.mclk_in(mclk), .rst_n_in(rst_n), .ce_in(ce), .clock_divisor_in(div),
    .check_kind_field_in(kind), .control_reg_in(cmd), .hold_read_in(rd),
    .serial_rx_line_in(line), .receive_holding_reg_out(hold), .status_reg_out(stat),
    .baud_tick_out(tick));
  task automatic bad(input logic [7:0] e, input logic [7:0] g);
    bad_count++;
    $display("BAD t=%0t exp=%h got=%h", $time, e, g);
  endtask
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) bad(e, g);
  endtask
  task automatic cmp_stat(input dbr_status_t e, input dbr_status_t g);
    n_tests++;
    if (g !== e) bad(8'(e), 8'(g));
  endtask
  task automatic check;
    cmp_byte(m_q.size() ? m_q[$] : 8'h00, hold);
    cmp_stat({m_rdy[0], m_ovr[0], m_pe[0], m_fe[0], m_on[0]}, stat);
  endtask
  task automatic pulse(input dbr_cmd_t c, input logic r);
    cmd = c;
    rd = r;
    @(negedge mclk);
    cmd = C_NO;
    rd = 1'b0;
    @(negedge mclk);
  endtask
  task automatic clear;
    pulse(C_ST, 1'b1);
    {m_rdy, m_ovr, m_pe, m_fe} = '0;
  endtask
  task automatic accept(input logic [7:0] d, input int pe, input int fe);
    if (m_rdy) m_ovr = 1;
    m_rdy = 1;
    m_pe |= pe;
    m_fe |= fe;
    m_q.push_back(d);
    if (m_pend) {m_on, m_pend} = '0;
  endtask
  task automatic frame(input logic [7:0] d, input logic err, input logic stop, input int acc);
    int par;
    case (kind)
      KIND_EVEN:  par = ^d;
      KIND_ODD:   par = ~^d;
      KIND_SPACE: par = 0;
      KIND_MARK:  par = 1;
      default:    par = -1;
    endcase
    if (par >= 0) par = par ^ err;
    term.send(d, par, stop, (div == 16'h0000) ? 1 : int'(div));
    repeat (8) @(negedge mclk);
    if (acc) accept(d, (par >= 0) && err, !stop);
  endtask
  task automatic count_ticks(input logic [7:0] e);
    int c;
    c = 0;
    repeat (320) begin
      @(negedge mclk);
      c += (tick !== 1'b0);
    end
    cmp_byte(e, 8'(c));
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    check();
    frame(8'($random(seed)), 1'b0, 1'b1, 0);
    check();
    pulse(C_EN, 1'b0);
    m_on = 1;
    check();
    $display("test reset_enable done");
    for (i = 0; i < 10; i++) begin
      kind = 3'(i / 2);
      frame(8'($random(seed)), i[0], 1'b1, 1);
      check();
      clear();
      check();
    end
    frame(8'($random(seed)), 1'b0, 1'b0, 1);
    check();
    clear();
    check();
    $display("test parity_framing done");
    frame(8'($random(seed)), 1'b0, 1'b1, 1);
    frame(8'($random(seed)), 1'b0, 1'b1, 1);
    check();
    pulse(C_ST, 1'b0);
    m_ovr = 0;
    check();
    pulse(C_NO, 1'b1);
    m_rdy = 0;
    check();
    $display("test overrun done");
    term.glitch(7);
    repeat (200) @(negedge mclk);
    check();
    term.glitch(9);
    repeat (200) @(negedge mclk);
    accept(8'hFF, 0, 0);
    check();
    clear();
    $display("test start_qual done");
    pulse(C_DI, 1'b0);
    m_on = 0;
    check();
    frame(8'($random(seed)), 1'b0, 1'b1, 0);
    check();
    pulse(C_EN, 1'b0);
    m_on = 1;
    fork
      frame(8'($random(seed)), 1'b0, 1'b1, 1);
      begin
        repeat (60) @(negedge mclk);
        pulse(C_DI, 1'b0);
        m_pend = 1;
        check();
      end
    join
    check();
    clear();
    pulse(C_EN, 1'b0);
    m_on = 1;
    $display("test disable done");
    fork
      frame(8'($random(seed)), 1'b0, 1'b1, 0);
      begin
        repeat (60) @(negedge mclk);
        pulse(C_RS, 1'b0);
        m_on = 0;
        check();
      end
    join
    check();
    pulse(C_EN, 1'b0);
    m_on = 1;
    frame(8'($random(seed)), 1'b0, 1'b1, 1);
    check();
    clear();
    $display("test rx_reset done");
    div = 16'h0000;
    count_ticks(8'h00);
    frame(8'($random(seed)), 1'b0, 1'b1, 0);
    check();
    div = 16'h0002;
    count_ticks(8'h0A);
    frame(8'($random(seed)), 1'b0, 1'b1, 1);
    check();
    $display("test divisor done");
    final_report();
  end
endmodule
